// ==== adc_sched_pkg.sv ====
// Purpose: Shared constants and types for the scan and calibration scheduler.
// Assumes: 20 MHz core clock; filter codes 0..5 stand for 10 Hz up to 1 kHz.
// Notes: Step times are whole milliseconds per filter code.
`default_nettype none
package adc_sched_pkg;
   // ==========================================================
   // Timing
   localparam int CLK_HZ = 20_000_000;
   localparam int MS_PER_S = 1000;
   localparam int TICK_CYCLES = CLK_HZ / MS_PER_S;
   localparam int CAL_PERIOD_MIN = 5;
   localparam int CAL_PERIOD_MS = CAL_PERIOD_MIN * 60 * MS_PER_S;
   // ==========================================================
   // Register map and fields
   localparam int ADDR_W = 5;
   localparam logic [4:0] REG_CTRL = 5'h00;
   localparam logic [4:0] REG_CHCFG = 5'h04;
   localparam logic [4:0] REG_STATUS = 5'h08;
   localparam logic [4:0] REG_IRQ_STAT = 5'h0c;
   localparam logic [4:0] REG_IRQ_MASK = 5'h10;
   localparam int CTRL_CAL_BIT = 0;
   localparam int CTRL_OPER_BIT = 1;
   localparam logic CTRL_CAL_RESET = 1'h1;
   localparam int CFG_EN_LSB = 0;
   localparam int CFG_TC_LSB = 4;
   localparam int CFG_FILT_LSB = 8;
   localparam int IRQ_SCAN = 0;
   localparam int IRQ_CAL = 1;
   localparam int IRQ_ERR = 2;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // ==========================================================
   // Steps, channels and errors
   localparam logic [1:0] KIND_CONV = 2'h0;
   localparam logic [1:0] KIND_SELF = 2'h1;
   localparam logic [1:0] KIND_OFFSET = 2'h2;
   localparam logic [2:0] CJC_CHAN = 3'h4;
   localparam logic [2:0] SCAN_END = 3'h5;
   localparam logic [2:0] FILT_MAX = 3'h5;
   localparam logic [2:0] ERR_NONE = 3'h0;
   localparam logic [2:0] ERR_HW = 3'h1;
   localparam logic [2:0] ERR_CFG = 3'h2;
   localparam logic [5:0] DNV_ALL = 6'h3f;
   // Milliseconds per step, index is the filter code.
   localparam logic [5:0][9:0] CONV_MS =
      {10'h007, 10'h009, 10'h00f, 10'h035, 10'h03f, 10'h12f};
   localparam logic [5:0][9:0] SELF_MS =
      {10'h009, 10'h00f, 10'h01b, 10'h067, 10'h07b, 10'h25b};
   localparam logic [5:0][9:0] OFF_MS =
      {10'h006, 10'h009, 10'h00f, 10'h035, 10'h03f, 10'h12f};
   typedef enum logic [4:0] {
      ST_TEST = 5'h01,
      ST_IDLE = 5'h02,
      ST_PICK = 5'h04,
      ST_STEP = 5'h08,
      ST_FAULT = 5'h10
   } state_type;
endpackage : adc_sched_pkg
`default_nettype wire

// ==== adc_autocal_scan_scheduler.sv ====
// Purpose: Scans four input channels and the cold-junction reference, slots calibration steps.
// Assumes: Converter status inputs come from logic on core_clk.
// Notes:
// Operation
// RQ1: Each scan converts every enabled channel in order, then the reference if thermocouples.
// RQ2: First calibration scan appends a self-calibration of the first enabled channel.
// RQ3: Next scan appends an offset calibration of that same channel.
// RQ4: Channels sharing an already calibrated filter setting get no calibration steps.
// RQ5: One more scan appends a self-calibration of the cold-junction reference.
// RQ6: After a cycle, normal scans run about five minutes, then a cycle restarts.
// RQ7: Every stop-to-operate change and every startup runs a full calibration cycle.
// RQ8: During startup input data are held and all six not-valid flags read one.
// RQ9: Startup runs calibration steps back to back with no conversion scans.
// RQ10: Failed power-up self-test keeps the indicator dark and reports a module error.
// RQ11: Indicator lights only after tests passed, and goes dark at once on errors.
// RQ12: Hardware faults and channel configuration faults are reported as module errors.
// RQ13: Over-range, under-range and open-circuit are data table flags, not module errors.
// RQ14: Conversion time follows the channel filter: 303, 63, 53, 15, 9 or 7 ms.
// RQ15: Self-calibration 603..9 ms and offset calibration 303..6 ms per filter setting.
// RQ16: Reference converts only with a thermocouple enabled, at lowest thermocouple filter.
// RQ17: Periodic calibration defaults on; toggling enable on then off starts one cycle.
// RQ18: Steps are timed by a millisecond tick; the sequencer advances on step completion.
// RQ19: A per-filter flag set records calibrated settings, cleared when a cycle starts.
//
// The implementer's own choices: register access over AXI4-Lite and the address map.
`default_nettype none
module adc_autocal_scan_scheduler #(
   parameter int TICK_CYCLES = adc_sched_pkg::TICK_CYCLES,
   parameter int CAL_PERIOD_MS = adc_sched_pkg::CAL_PERIOD_MS
) (
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic awvalid,
   output logic awready,
   input wire logic [4:0] awaddr,
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   input wire logic arvalid,
   output logic arready,
   input wire logic [4:0] araddr,
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   input wire logic selfTestDone,
   input wire logic selfTestPass,
   input wire logic hwFault,
   input wire logic [3:0] overRange,
   input wire logic [3:0] underRange,
   input wire logic [3:0] openCircuit,
   output logic convStart,
   output logic [2:0] convChan,
   output logic [1:0] convKind,
   output logic [2:0] convFilter,
   output logic [11:0] chanFlags,
   output logic [5:0] dataNotValidFlags,
   output logic statusLed,
   output logic [2:0] moduleErrorType,
   output logic irq
);
   // ==========================================================
   // State
   typedef struct packed {
      adc_sched_pkg::state_type state;
      logic awHave;
      logic [4:0] awAddr;
      logic wHave;
      logic [31:0] wData;
      logic [3:0] wStrb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic ctrlCal;
      logic ctrlOper;
      logic [3:0] chEn;
      logic [3:0] chTc;
      logic [11:0] chFilt;
      logic [2:0] irqStat;
      logic [2:0] irqMask;
      logic calPrev;
      logic operPrev;
      logic testPassed;
      logic hwErr;
      logic [2:0] errType;
      logic led;
      logic startupMode;
      logic calActive;
      logic calSub;
      logic cjcDone;
      logic finish;
      logic [1:0] calChan;
      logic [5:0] calDone;
      logic [2:0] idx;
      logic [15:0] tickCnt;
      logic [18:0] periodMs;
      logic [9:0] stepMs;
      logic convStart;
      logic [2:0] convChan;
      logic [1:0] convKind;
      logic [2:0] convFilt;
      logic [11:0] chanFlags;
   } sched_type;

   sched_type s;
   sched_type next_s;
   logic tick;
   logic anyTc;
   logic cfgBad;
   logic tgtValid;
   logic [1:0] tgtChan;
   logic [2:0] cjcFilt;
   logic issue;
   logic startCyc;
   logic finishNow;
   logic [2:0] ev;
   logic [2:0] iChan;
   logic [1:0] iKind;
   logic [2:0] iFilt;
   logic [31:0] tmp;

   function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] d,
                                          input logic [3:0] strb);
      logic [31:0] m;
      for (int b = 0; b < 4; b++) begin
         m[8*b +: 8] = {8{strb[b]}};
      end
      return (old & ~m) | (d & m);
   endfunction : wmerge

   // ==========================================================
   // Channel summaries
   always_comb begin
      anyTc = |(s.chEn & s.chTc);
      cfgBad = 1'b0;
      tgtValid = 1'b0;
      tgtChan = 2'h0;
      cjcFilt = adc_sched_pkg::FILT_MAX;
      for (int c = 3; c >= 0; c--) begin
         if (s.chEn[c] && s.chFilt[3*c +: 3] > adc_sched_pkg::FILT_MAX) begin
            cfgBad = 1'b1;
         end
         // RQ4 skip calibrated filter
         if (s.chEn[c] && !s.calDone[s.chFilt[3*c +: 3]]) begin
            tgtValid = 1'b1;
            tgtChan = 2'(c);
         end
         // RQ16 lowest thermocouple filter
         if (s.chEn[c] && s.chTc[c] && s.chFilt[3*c +: 3] < cjcFilt) begin
            cjcFilt = s.chFilt[3*c +: 3];
         end
      end
   end

   // ==========================================================
   // Next state
   always_comb begin
      next_s = s;
      next_s.convStart = 1'b0;
      ev = 3'h0;
      issue = 1'b0;
      startCyc = 1'b0;
      finishNow = 1'b0;
      iChan = 3'h0;
      iKind = adc_sched_pkg::KIND_CONV;
      iFilt = 3'h0;
      tmp = 32'h0;
      // RQ18 millisecond tick
      tick = s.tickCnt == 16'(TICK_CYCLES - 1);
      next_s.tickCnt = tick ? 16'h0 : s.tickCnt + 16'h1;

      if (awvalid && !s.awHave) begin
         next_s.awHave = 1'b1;
         next_s.awAddr = awaddr;
      end
      if (wvalid && !s.wHave) begin
         next_s.wHave = 1'b1;
         next_s.wData = wdata;
         next_s.wStrb = wstrb;
      end
      if (s.bvalid && bready) begin
         next_s.bvalid = 1'b0;
      end
      if (s.awHave && s.wHave && !s.bvalid) begin
         next_s.awHave = 1'b0;
         next_s.wHave = 1'b0;
         next_s.bvalid = 1'b1;
         next_s.bresp = adc_sched_pkg::RESP_OKAY;
         case (s.awAddr)
            adc_sched_pkg::REG_CTRL: begin
               tmp = wmerge({30'h0, s.ctrlOper, s.ctrlCal}, s.wData, s.wStrb);
               next_s.ctrlCal = tmp[adc_sched_pkg::CTRL_CAL_BIT];
               next_s.ctrlOper = tmp[adc_sched_pkg::CTRL_OPER_BIT];
            end
            adc_sched_pkg::REG_CHCFG: begin
               tmp = wmerge({12'h0, s.chFilt, s.chTc, s.chEn}, s.wData, s.wStrb);
               next_s.chEn = tmp[adc_sched_pkg::CFG_EN_LSB +: 4];
               next_s.chTc = tmp[adc_sched_pkg::CFG_TC_LSB +: 4];
               next_s.chFilt = tmp[adc_sched_pkg::CFG_FILT_LSB +: 12];
            end
            adc_sched_pkg::REG_IRQ_STAT: begin
               if (s.wStrb[0]) begin
                  next_s.irqStat = s.irqStat & ~s.wData[2:0];
               end
            end
            adc_sched_pkg::REG_IRQ_MASK: begin
               tmp = wmerge({29'h0, s.irqMask}, s.wData, s.wStrb);
               next_s.irqMask = tmp[2:0];
            end
            default: begin
               next_s.bresp = adc_sched_pkg::RESP_SLVERR;
            end
         endcase
      end
      if (arvalid && !s.rvalid) begin
         next_s.rvalid = 1'b1;
         next_s.rresp = adc_sched_pkg::RESP_OKAY;
         case (araddr)
            adc_sched_pkg::REG_CTRL: next_s.rdata = {30'h0, s.ctrlOper, s.ctrlCal};
            adc_sched_pkg::REG_CHCFG: next_s.rdata = {12'h0, s.chFilt, s.chTc, s.chEn};
            adc_sched_pkg::REG_STATUS: begin
               next_s.rdata = {9'h0, s.chanFlags, s.errType, s.calActive, s.startupMode,
                               s.led, s.state};
            end
            adc_sched_pkg::REG_IRQ_STAT: next_s.rdata = {29'h0, s.irqStat};
            adc_sched_pkg::REG_IRQ_MASK: next_s.rdata = {29'h0, s.irqMask};
            default: begin
               next_s.rdata = 32'h0;
               next_s.rresp = adc_sched_pkg::RESP_SLVERR;
            end
         endcase
      end else if (s.rvalid && rready) begin
         next_s.rvalid = 1'b0;
      end

      // RQ12 hardware fault latch
      if (hwFault) begin
         next_s.hwErr = 1'b1;
      end
      next_s.operPrev = s.ctrlOper;
      next_s.calPrev = s.ctrlCal;
      // RQ6 period timer
      if (s.testPassed && !s.calActive && s.ctrlCal && tick) begin
         next_s.periodMs = s.periodMs + 19'h1;
         if (s.periodMs == 19'(CAL_PERIOD_MS - 1)) begin
            startCyc = 1'b1;
         end
      end
      // RQ17 on-then-off request
      if (s.calPrev && !s.ctrlCal && s.testPassed && !s.calActive) begin
         startCyc = 1'b1;
      end

      case (s.state)
         adc_sched_pkg::ST_TEST: begin
            if (selfTestDone) begin
               // RQ10 self-test outcome
               if (selfTestPass) begin
                  next_s.testPassed = 1'b1;
                  startCyc = 1'b1;
                  next_s.state = adc_sched_pkg::ST_PICK;
               end else begin
                  next_s.hwErr = 1'b1;
                  next_s.state = adc_sched_pkg::ST_FAULT;
               end
            end
         end
         adc_sched_pkg::ST_FAULT: begin
            next_s.state = adc_sched_pkg::ST_FAULT;
         end
         adc_sched_pkg::ST_IDLE: begin
            if (s.errType == adc_sched_pkg::ERR_NONE && (s.ctrlOper || s.startupMode)) begin
               next_s.state = adc_sched_pkg::ST_PICK;
            end
         end
         adc_sched_pkg::ST_PICK: begin
            // RQ9 startup skips conversions
            if (s.errType != adc_sched_pkg::ERR_NONE || (!s.ctrlOper && !s.startupMode)) begin
               next_s.state = adc_sched_pkg::ST_IDLE;
            end else if (!s.startupMode && s.idx != adc_sched_pkg::SCAN_END) begin
               // RQ1 channel then reference
               next_s.idx = s.idx + 3'h1;
               if (s.idx == adc_sched_pkg::CJC_CHAN) begin
                  issue = anyTc;
                  iChan = adc_sched_pkg::CJC_CHAN;
                  iFilt = cjcFilt;
               end else begin
                  issue = s.chEn[s.idx[1:0]];
                  iChan = s.idx;
                  iFilt = s.chFilt[3*s.idx[1:0] +: 3];
               end
            end else begin
               next_s.idx = 3'h0;
               ev[adc_sched_pkg::IRQ_SCAN] = !s.startupMode;
               if (s.calActive) begin
                  issue = 1'b1;
                  if (s.calSub) begin
                     // RQ3 offset of same channel
                     iKind = adc_sched_pkg::KIND_OFFSET;
                     iChan = {1'b0, s.calChan};
                     iFilt = s.chFilt[3*s.calChan +: 3];
                     next_s.calDone[iFilt] = 1'b1;
                     next_s.calSub = 1'b0;
                  end else if (tgtValid) begin
                     // RQ2 channel self-calibration
                     iKind = adc_sched_pkg::KIND_SELF;
                     iChan = {1'b0, tgtChan};
                     iFilt = s.chFilt[3*tgtChan +: 3];
                     next_s.calChan = tgtChan;
                     next_s.calSub = 1'b1;
                  end else if (anyTc && !s.cjcDone) begin
                     // RQ5 reference self-calibration
                     iKind = adc_sched_pkg::KIND_SELF;
                     iChan = adc_sched_pkg::CJC_CHAN;
                     iFilt = cjcFilt;
                     next_s.cjcDone = 1'b1;
                     next_s.finish = 1'b1;
                  end else begin
                     issue = 1'b0;
                     finishNow = 1'b1;
                  end
               end
            end
         end
         adc_sched_pkg::ST_STEP: begin
            if (tick) begin
               next_s.stepMs = s.stepMs - 10'h1;
               if (s.stepMs == 10'h1) begin
                  next_s.state = adc_sched_pkg::ST_PICK;
                  finishNow = s.finish;
                  // RQ13 range flags in data table
                  if (s.convKind == adc_sched_pkg::KIND_CONV && !s.convChan[2]
                      && !s.startupMode) begin
                     next_s.chanFlags[s.convChan[1:0]] = overRange[s.convChan[1:0]];
                     next_s.chanFlags[4 + s.convChan[1:0]] = underRange[s.convChan[1:0]];
                     next_s.chanFlags[8 + s.convChan[1:0]] = openCircuit[s.convChan[1:0]];
                  end
               end
            end
         end
         default: begin
            next_s.state = adc_sched_pkg::ST_FAULT;
         end
      endcase

      // RQ14 step length
      if (issue) begin
         next_s.state = adc_sched_pkg::ST_STEP;
         next_s.convStart = 1'b1;
         next_s.convChan = iChan;
         next_s.convKind = iKind;
         next_s.convFilt = iFilt;
         // RQ15 calibration step lengths
         case (iKind)
            adc_sched_pkg::KIND_SELF: next_s.stepMs = adc_sched_pkg::SELF_MS[iFilt];
            adc_sched_pkg::KIND_OFFSET: next_s.stepMs = adc_sched_pkg::OFF_MS[iFilt];
            default: next_s.stepMs = adc_sched_pkg::CONV_MS[iFilt];
         endcase
      end
      if (finishNow) begin
         next_s.calActive = 1'b0;
         next_s.startupMode = 1'b0;
         next_s.finish = 1'b0;
         next_s.periodMs = 19'h0;
         ev[adc_sched_pkg::IRQ_CAL] = 1'b1;
      end
      // RQ7 stop-to-operate forces startup cycle
      if (s.ctrlOper && !s.operPrev && s.testPassed
          && s.state != adc_sched_pkg::ST_FAULT) begin
         startCyc = 1'b1;
         next_s.startupMode = 1'b1;
      end
      // RQ19 fresh calibrated set
      if (startCyc) begin
         next_s.calActive = 1'b1;
         next_s.calDone = 6'h0;
         next_s.calSub = 1'b0;
         next_s.cjcDone = 1'b0;
         next_s.finish = 1'b0;
         next_s.periodMs = 19'h0;
         next_s.idx = 3'h0;
      end
      if (next_s.hwErr) begin
         next_s.errType = adc_sched_pkg::ERR_HW;
      end else if (cfgBad) begin
         next_s.errType = adc_sched_pkg::ERR_CFG;
      end else begin
         next_s.errType = adc_sched_pkg::ERR_NONE;
      end
      // RQ11 indicator
      next_s.led = next_s.testPassed && next_s.errType == adc_sched_pkg::ERR_NONE;
      ev[adc_sched_pkg::IRQ_ERR] = next_s.errType != adc_sched_pkg::ERR_NONE
                                   && s.errType == adc_sched_pkg::ERR_NONE;
      // New events win over a clear in the same cycle.
      next_s.irqStat = next_s.irqStat | ev;
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         s <= '0;
         s.state <= adc_sched_pkg::ST_TEST;
         s.ctrlCal <= adc_sched_pkg::CTRL_CAL_RESET;
         s.calPrev <= adc_sched_pkg::CTRL_CAL_RESET;
         s.startupMode <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   // ==========================================================
   // Outputs
   assign awready = !s.awHave;
   assign wready = !s.wHave;
   assign bvalid = s.bvalid;
   assign bresp = s.bresp;
   assign arready = !s.rvalid;
   assign rvalid = s.rvalid;
   assign rdata = s.rdata;
   assign rresp = s.rresp;
   assign convStart = s.convStart;
   assign convChan = s.convChan;
   assign convKind = s.convKind;
   assign convFilter = s.convFilt;
   assign chanFlags = s.chanFlags;
   // RQ8 flags while starting
   assign dataNotValidFlags = s.startupMode ? adc_sched_pkg::DNV_ALL : 6'h0;
   assign statusLed = s.led;
   assign moduleErrorType = s.errType;
   assign irq = |(s.irqStat & s.irqMask);

   // ==========================================================
   // Checks
   AST_FAULT_DARK: assert property (@(posedge core_clk) disable iff (!arst_n) // RQ10
      s.state == adc_sched_pkg::ST_FAULT |-> !statusLed
      && moduleErrorType == adc_sched_pkg::ERR_HW) else $error("Faulted module not dark.");
   AST_LED_ERR: assert property (@(posedge core_clk) disable iff (!arst_n) // RQ11
      moduleErrorType != adc_sched_pkg::ERR_NONE || !s.testPassed |-> !statusLed)
      else $error("Indicator lit with error.");
   AST_HW_REPORT: assert property (@(posedge core_clk) disable iff (!arst_n) // RQ12
      hwFault |=> moduleErrorType == adc_sched_pkg::ERR_HW) else $error("Fault not reported.");
   AST_TEST_DNV: assert property (@(posedge core_clk) disable iff (!arst_n) // RQ8
      s.state == adc_sched_pkg::ST_TEST |-> dataNotValidFlags == 6'h3f)
      else $error("Data valid before startup.");
   AST_HOLD_DATA: assert property (@(posedge core_clk) disable iff (!arst_n) // RQ8
      s.startupMode && $past(s.startupMode) |-> $stable(chanFlags))
      else $error("Data changed during startup.");
   AST_NO_SCAN: assert property (@(posedge core_clk) disable iff (!arst_n) // RQ9
      convStart && $past(s.startupMode) |-> convKind != adc_sched_pkg::KIND_CONV)
      else $error("Conversion during startup.");
   AST_CJC_TC: assert property (@(posedge core_clk) disable iff (!arst_n) // RQ16
      convStart && convChan == adc_sched_pkg::CJC_CHAN |-> $past(anyTc))
      else $error("Reference step without thermocouple.");
   AST_NO_RECAL: assert property (@(posedge core_clk) disable iff (!arst_n) // RQ4
      convStart && convKind == adc_sched_pkg::KIND_SELF && !convChan[2]
      |-> !s.calDone[convFilter] ##1 !convStart[*2]) else $error("Filter calibrated twice.");
   AST_STEP_WAIT: assert property (@(posedge core_clk) disable iff (!arst_n) // RQ18
      s.state == adc_sched_pkg::ST_STEP && !tick |=> s.state == adc_sched_pkg::ST_STEP
      && $stable(s.stepMs)) else $error("Step ended off tick.");
   AST_OPER_CAL: assert property (@(posedge core_clk) disable iff (!arst_n) // RQ7
      s.ctrlOper && !s.operPrev && s.testPassed && s.state != adc_sched_pkg::ST_FAULT
      |=> s.calActive && s.startupMode) else $error("No cycle on mode change.");
endmodule : adc_autocal_scan_scheduler
`default_nettype wire

// ==== front_end_model.sv ====
// Purpose: Stand-in for the converter front end and power-up test logic.
// Assumes: Same clock as the scheduler.
// Notes: Range flags are fixed levels so the data table bits are known.
`default_nettype none
module front_end_model #(
   parameter int TEST_CYCLES = 10
) (
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic hwFault,
   output logic selfTestDone,
   output logic selfTestPass,
   output logic [3:0] overRange,
   output logic [3:0] underRange,
   output logic [3:0] openCircuit
);
   timeunit 1ns;
   timeprecision 1ps;
   int cnt;
   assign overRange = 4'h1;
   assign underRange = 4'h2;
   assign openCircuit = 4'h0;
   assign selfTestPass = !hwFault;
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         cnt <= 0;
         selfTestDone <= 1'b0;
      end else begin
         cnt <= (cnt < TEST_CYCLES) ? cnt + 1 : cnt;
         selfTestDone <= (cnt == TEST_CYCLES - 1);
      end
   end
endmodule : front_end_model
`default_nettype wire

// ==== tb_top.sv ====
// Purpose: Self-checking bench for the scan scheduler.
// Assumes: Short tick and calibration period parameters.
// Notes: Step order is judged from the convStart pulses.
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int TK = 4;
   logic core_clk, awready, wready, bvalid, arready, rvalid, convStart;
   logic arst_n = 1'b0, awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
   logic hwFault = 1'b0, bready = 1'b1, rready = 1'b1;
   logic [3:0] wstrb = 4'hf;
   logic [4:0] awaddr = 5'h0, araddr = 5'h0;
   logic [31:0] wdata = 32'h0, rdata, rd;
   logic [1:0] bresp, rresp, convKind, rs;
   logic [2:0] convChan, convFilter, moduleErrorType;
   logic [11:0] chanFlags;
   logic [5:0] dataNotValidFlags;
   logic statusLed, irq, selfTestDone, selfTestPass;
   logic [3:0] overRange, underRange, openCircuit;
   int errCount = 0, checksDone = 0, cyc = 0, n;
   time t0;
   adc_autocal_scan_scheduler #(.TICK_CYCLES(TK), .CAL_PERIOD_MS(200))
      adc_autocal_scan_scheduler_i (.*);
   front_end_model front_end_model_i (.*);
   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end
   // The ceiling is about seven times the expected run.
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         errCount++;
         results();
      end
   end
   task automatic results();
      if (errCount == 0 && checksDone > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : results
   task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
      checksDone++;
      if (seen !== exp) begin
         errCount++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic axiWr(input logic [4:0] a, input logic [31:0] d, output logic [1:0] r);
      logic ta, tw, tb;
      @(posedge core_clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      do begin
         @(negedge core_clk);
         ta = awvalid && awready;
         tw = wvalid && wready;
         tb = bvalid;
         r = bresp;
         @(posedge core_clk);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
      end while (!tb);
   endtask : axiWr
   task automatic axiRd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
      logic ta, tr;
      @(posedge core_clk);
      araddr <= a;
      arvalid <= 1'b1;
      do begin
         @(negedge core_clk);
         ta = arvalid && arready;
         tr = rvalid;
         d = rdata;
         r = rresp;
         @(posedge core_clk);
         if (ta) arvalid <= 1'b0;
      end while (!tr);
   endtask : axiRd
   task automatic waitStart();
      int k;
      k = 0;
      do begin
         @(negedge core_clk);
         k++;
      end while (convStart !== 1'b1 && k < 8000);
      chk(k < 8000, 1'b1);
   endtask : waitStart
   task automatic step(input logic [2:0] c, input logic [1:0] k, input logic [2:0] f);
      waitStart();
      chk({convChan, convKind, convFilter}, {c, k, f});
   endtask : step
   task automatic sBoot();
      chk(dataNotValidFlags, 6'h3f);
      chk(statusLed, 1'b0);
      repeat (20) @(negedge core_clk);
      chk(statusLed, 1'b1);
      axiRd(adc_sched_pkg::REG_CTRL, rd, rs);
      chk(rd, 32'h1);
   endtask : sBoot
   // Two thermocouples share one filter, so one calibration pair serves both.
   task automatic sStartup();
      axiWr(adc_sched_pkg::REG_CHCFG, 32'h0000_1233, rs);
      axiWr(adc_sched_pkg::REG_CTRL, 32'h0000_0003, rs);
      step(3'h0, adc_sched_pkg::KIND_SELF, 3'h2);
      step(3'h0, adc_sched_pkg::KIND_OFFSET, 3'h2);
      chk(dataNotValidFlags, 6'h3f);
      step(adc_sched_pkg::CJC_CHAN, adc_sched_pkg::KIND_SELF, 3'h2);
   endtask : sStartup
   task automatic sScan();
      step(3'h0, adc_sched_pkg::KIND_CONV, 3'h2);
      t0 = $time;
      step(3'h1, adc_sched_pkg::KIND_CONV, 3'h2);
      n = int'(($time - t0) / 50);
      chk(n > TK * 52 && n <= TK * 53 + 8, 1'b1);
      step(adc_sched_pkg::CJC_CHAN, adc_sched_pkg::KIND_CONV, 3'h2);
      chk(dataNotValidFlags, 6'h00);
      chk(chanFlags, 12'h021);
      chk(moduleErrorType, adc_sched_pkg::ERR_NONE);
   endtask : sScan
   task automatic sPeriodic();
      n = 0;
      do begin
         waitStart();
         n++;
      end while (convKind === adc_sched_pkg::KIND_CONV && n < 30);
      chk(n > 3, 1'b1);
      chk({convChan, convKind}, {3'h0, adc_sched_pkg::KIND_SELF});
      for (int i = 0; i < 2; i++) begin
         step(3'h0, adc_sched_pkg::KIND_CONV, 3'h2);
         step(3'h1, adc_sched_pkg::KIND_CONV, 3'h2);
         step(adc_sched_pkg::CJC_CHAN, adc_sched_pkg::KIND_CONV, 3'h2);
         step(i ? 3'h4 : 3'h0, i ? 2'h1 : 2'h2, 3'h2);
      end
      waitStart();
      axiWr(adc_sched_pkg::REG_CTRL, 32'h2, rs);
      n = 0;
      do begin
         waitStart();
         n++;
      end while (convKind === adc_sched_pkg::KIND_CONV && n < 30);
      chk({convChan, convKind}, {3'h0, adc_sched_pkg::KIND_SELF});
   endtask : sPeriodic
   task automatic sRegs();
      axiWr(adc_sched_pkg::REG_IRQ_MASK, 32'h1, rs);
      @(negedge core_clk);
      chk({rs, irq}, {adc_sched_pkg::RESP_OKAY, 1'b1});
      axiWr(adc_sched_pkg::REG_IRQ_STAT, 32'h7, rs);
      @(negedge core_clk);
      chk(irq, 1'b0);
      axiRd(5'h14, rd, rs);
      chk({rs, rd}, {adc_sched_pkg::RESP_SLVERR, 32'h0});
      axiWr(5'h14, 32'h1, rs);
      chk(rs, adc_sched_pkg::RESP_SLVERR);
   endtask : sRegs
   task automatic sFault();
      hwFault <= 1'b1;
      repeat (4) @(negedge core_clk);
      chk({statusLed, moduleErrorType}, {1'b0, adc_sched_pkg::ERR_HW});
      axiRd(adc_sched_pkg::REG_STATUS, rd, rs);
      chk(rd[10:8], adc_sched_pkg::ERR_HW);
      // A faulty front end must also fail the power-up test after a reset.
      hwFault <= 1'b0;
      arst_n <= 1'b0;
      repeat (2) @(posedge core_clk);
      arst_n <= 1'b1;
      repeat (2) @(posedge core_clk);
      hwFault <= 1'b1;
      repeat (20) @(negedge core_clk);
      axiRd(adc_sched_pkg::REG_STATUS, rd, rs);
      chk({rd[10:8], rd[5:0]}, {adc_sched_pkg::ERR_HW, 6'h10});
   endtask : sFault
   initial begin
      repeat (6) @(posedge core_clk);
      arst_n <= 1'b1;
      sBoot();
      sStartup();
      sScan();
      sPeriodic();
      sRegs();
      sFault();
      results();
   end
endmodule : tb_top
`default_nettype wire
